/* ibd_decode.sv */
// Address decode, cross-bus sequencing, placement register and freeze responses.
// Assumes masters present one request with req held until done; APB from software.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
// What this block does
// [R1] Placement bit ls_mem_enable turns load/store memory decode on or off; reset from config word.
// [R2] ls_mem_placement code selects one of four SRAM placements.
// [R3] if_mem_enable is stored only; instruction-bus memory accesses go external except where an enabled load/store block overlaps them.
// [R4] cross_bus_data_enable resets to 1; it is stored and read back only, and clearing it does not change the decode of cross-bus data accesses.
// [R5] if_mem_placement holds the instruction memory placement, reset from config word.
// [R6] Enables and placements reset from config word; other bits zero except cross enable.
// [R7] Placement register is writable and readable only in supervisor mode.
// [R8] Unimplemented location inside memory block gives machine check.
// [R9] Control registers and peripherals occupy a fixed 512K region; registers top 4K.
// [R10] That region never disables, is data only; instruction access gives transfer error.
// [R11] Memory control registers stay at fixed addresses regardless of placement.
// [R12] Accesses to nonexistent on-chip memory become external bus cycles.
// [R13] Cross-bus accesses take at least three clocks.
// [R14] Instruction-bus accesses to load/store memory are single, never burst.
// [R15] Registers unavailable during cross-bus access except to an APB transfer readied at its accept edge; no pipelining of cross-bus accesses.
// [R16] The core asserts freeze on debug entry; its side drives the freeze input.
// [R17] Freeze without debug mode leaves the watch timer on its programmed enable.
// [R18] Debug mode with freeze or breakpoint forces the watch timer on.
// [R19] In normal running a breakpoint ends a hung cycle via the watch timer.
// [R20] Freeze with freeze_stop_timers stops the periodic timer, overriding its enable.
// [R21] Freeze with freeze_stop_timers holds the decrementer.
// [R22] During freeze, lock bits may be set and cleared.
// [R23] Reserved placement bits read zero and ignore writes.
module ibd_decode import ibd_pkg::*; #(
	parameter int SRAM_BYTES = 4096,
	parameter int BLOCK_BYTES = 8192
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic        pprot_priv,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [31:0] config_word,
	input  wire logic        req,
	input  wire logic [31:0] req_addr,
	input  wire logic        req_instr,
	input  wire logic        req_from_if,
	input  wire logic        req_burst,
	output logic             done,
	output ibd_target_t      target,
	output logic             out_burst,
	output logic             transfer_error_ack,
	output logic             machine_check,
	input  wire logic        freeze,
	input  wire logic        debug_mode_en,
	input  wire logic        nm_breakpoint,
	input  wire logic        bus_cycle_hung,
	output logic             watch_timer_on,
	output logic             watch_timer_force_end,
	output logic             pit_run,
	input  wire logic        periodic_irq_enable,
	output logic             decrementer_run
);
	logic        ls_mem_enable;
	logic [1:0]  ls_mem_placement;
	logic        if_mem_enable;
	logic        cross_bus_data_enable;
	logic [1:0]  if_mem_placement;
	logic        freeze_stop_timers;
	logic        watch_timer_enable;
	logic        reg_lock;
	logic        cfg_seen;
	logic [1:0]  xbus_cnt;
	logic        xbus_busy;
	logic        wr_acc;
	logic        rd_acc;
	logic        xbus_hit;
	ibd_target_t next_target;

	assign wr_acc = psel && penable && pready && pwrite;
	assign rd_acc = psel && penable && pready && !pwrite;

	function automatic logic in_block(input logic [31:0] a, input logic [1:0] pl, input logic [31:0] endlo,
		input logic [31:0] endhi, input int sz);
		logic [31:0] base;
		base = 32'h0;
		case (pl)
			2'b00: base = 32'h0;
			2'b01: base = endlo + 32'h4 - 32'(sz);
			2'b10: base = IBD_TOP_START;
			default: base = endhi + 32'h4 - 32'(sz);
		endcase
		return (a >= base) && (a - base < 32'(sz));
	endfunction

	// Placement register writes, supervisor only, reserved bits dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ls_mem_enable         <= 1'b0;
			ls_mem_placement      <= 2'b00;
			if_mem_enable         <= 1'b0;
			cross_bus_data_enable <= IBD_XBUS_RESET; // [R4]
			if_mem_placement      <= 2'b00;
			cfg_seen              <= 1'b0;
		end else if (!cfg_seen) begin
			cfg_seen         <= 1'b1;
			ls_mem_enable    <= config_word[IBD_LS_EN_BIT]; // [R6]
			ls_mem_placement <= config_word[IBD_LS_PL_LSB +: 2];
			if_mem_enable    <= config_word[IBD_IF_EN_BIT];
			if_mem_placement <= config_word[IBD_IF_PL_LSB +: 2];
		end else if (wr_acc && paddr == IBD_PLACEMENT_ADDR && pprot_priv) begin // [R7]
			ls_mem_enable         <= pwdata[IBD_LS_EN_BIT]; // [R1]
			ls_mem_placement      <= pwdata[IBD_LS_PL_LSB +: 2]; // [R2]
			if_mem_enable         <= pwdata[IBD_IF_EN_BIT]; // [R3]
			cross_bus_data_enable <= pwdata[IBD_XBUS_EN_BIT];
			if_mem_placement      <= pwdata[IBD_IF_PL_LSB +: 2]; // [R5] [R23]
		end
	end

	// Config, watch timer control and lock; locked config changes only under freeze
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			freeze_stop_timers <= 1'b0;
			watch_timer_enable <= 1'b0;
			reg_lock           <= 1'b0;
		end else if (wr_acc && pprot_priv) begin
			if (paddr == IBD_CONFIG_ADDR && (!reg_lock || freeze))
				freeze_stop_timers <= pwdata[IBD_FRZ_STOP_BIT];
			else if (paddr == IBD_CTRL_ADDR)
				watch_timer_enable <= pwdata[IBD_WT_EN_BIT];
			else if (paddr == IBD_LOCK_ADDR) begin
				if (freeze)
					reg_lock <= pwdata[IBD_LOCK_BIT]; // [R22]
				else if (pwdata[IBD_LOCK_BIT])
					reg_lock <= 1'b1;
			end
		end
	end

	// APB answer; pready withheld while xbus_busy, so only a transfer readied at the accept edge overlaps a cross-bus access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !pready && !xbus_busy; // [R15]
			pslverr <= 1'b0;
			if (psel && !pready && !xbus_busy) begin
				prdata <= 32'h0;
				if (!pprot_priv)
					pslverr <= 1'b1;
				else if (paddr == IBD_PLACEMENT_ADDR)
					prdata <= {ls_mem_enable, 7'h0, ls_mem_placement, 6'h0, if_mem_enable,
						cross_bus_data_enable, 6'h0, if_mem_placement, 6'h0};
				else if (paddr == IBD_CONFIG_ADDR)
					prdata <= {freeze_stop_timers, 31'h0};
				else if (paddr == IBD_CTRL_ADDR)
					prdata <= {31'h0, watch_timer_enable};
				else if (paddr == IBD_LOCK_ADDR)
					prdata <= {31'h0, reg_lock};
				else if (paddr == IBD_STATUS_ADDR)
					prdata <= {28'h0, xbus_busy, watch_timer_on, pit_run, decrementer_run};
				else
					pslverr <= 1'b1;
			end
		end
	end

	// Combinational target selection
	always_comb begin
		next_target = IBD_T_EXT; // [R12]
		if (req_addr >= IBD_REG_BASE && req_addr <= IBD_REG_LIMIT) begin // [R9]
			if (req_instr)
				next_target = IBD_T_ERR; // [R10]
			else if (req_addr >= IBD_CREG_BASE)
				next_target = IBD_T_CREG; // [R11]
			else
				next_target = IBD_T_PERIPH;
		end else if (ls_mem_enable && in_block(req_addr, ls_mem_placement, IBD_LS_END_LOW, IBD_LS_END_HIGH,
			BLOCK_BYTES)) begin // [R1]
			if (in_block(req_addr, ls_mem_placement, IBD_LS_END_LOW, IBD_LS_END_HIGH, SRAM_BYTES))
				next_target = IBD_T_SRAM; // [R2]
			else
				next_target = IBD_T_MCHK; // [R8]
		end else if (in_block(req_addr, if_mem_placement, IBD_IF_END_LOW, IBD_IF_END_HIGH, BLOCK_BYTES)) begin
			next_target = IBD_T_EXT; // [R3] [R4]
		end
	end

	assign xbus_hit = req_from_if && next_target == IBD_T_SRAM;

	// Request sequencing: cross-bus accesses held for three clocks and never overlapped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			target             <= IBD_T_NONE;
			done               <= 1'b0;
			out_burst          <= 1'b0;
			transfer_error_ack <= 1'b0;
			machine_check      <= 1'b0;
			xbus_busy          <= 1'b0;
			xbus_cnt           <= 2'd0;
		end else begin
			done               <= 1'b0;
			transfer_error_ack <= 1'b0;
			machine_check      <= 1'b0;
			if (xbus_busy) begin
				if (xbus_cnt == 2'(IBD_XBUS_CYCLES - 2)) begin // [R13]
					xbus_busy <= 1'b0;
					done      <= 1'b1;
				end
				xbus_cnt <= xbus_cnt + 2'd1;
			end else if (req && !done) begin
				target <= xbus_hit ? IBD_T_XBUS : next_target; // [R13]
				if (xbus_hit) begin
					xbus_busy <= 1'b1; // [R15]
					xbus_cnt  <= 2'd0;
					out_burst <= 1'b0; // [R14]
				end else begin
					done               <= 1'b1;
					out_burst          <= req_burst;
					transfer_error_ack <= next_target == IBD_T_ERR;
					machine_check      <= next_target == IBD_T_MCHK;
				end
			end
		end
	end

	// Freeze responses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			watch_timer_on        <= 1'b0;
			watch_timer_force_end <= 1'b0;
			pit_run               <= 1'b0;
			decrementer_run       <= 1'b0;
		end else begin
			watch_timer_on <= watch_timer_enable || (debug_mode_en && (freeze || nm_breakpoint)); // [R17] [R18]
			watch_timer_force_end <= nm_breakpoint && bus_cycle_hung && !freeze; // [R19]
			pit_run <= periodic_irq_enable && !(freeze && freeze_stop_timers); // [R20]
			decrementer_run <= !(freeze && freeze_stop_timers); // [R21]
		end
	end
endmodule

/* ibd_pkg.sv */
// Package for the internal bus decode and freeze block.
// Assumes one system clock and an APB register port.
package ibd_pkg;
	localparam logic [31:0] IBD_PLACEMENT_ADDR = 32'h8007fc20;
	localparam logic [31:0] IBD_CONFIG_ADDR    = 32'h8007fc00;
	localparam logic [31:0] IBD_CTRL_ADDR      = 32'h8007fc48;
	localparam logic [31:0] IBD_LOCK_ADDR      = 32'h8007fc80;
	localparam logic [31:0] IBD_STATUS_ADDR    = 32'h8007fc84;
	localparam int IBD_LS_EN_BIT    = 31;
	localparam int IBD_LS_PL_LSB    = 22;
	localparam int IBD_IF_EN_BIT    = 15;
	localparam int IBD_XBUS_EN_BIT  = 14;
	localparam int IBD_IF_PL_LSB    = 6;
	localparam int IBD_FRZ_STOP_BIT = 31;
	localparam int IBD_WT_EN_BIT    = 0;
	localparam int IBD_LOCK_BIT     = 0;
	localparam logic IBD_XBUS_RESET = 1'b1;
	localparam logic [31:0] IBD_REG_BASE    = 32'h80000000;
	localparam logic [31:0] IBD_REG_LIMIT   = 32'h8007ffff;
	localparam logic [31:0] IBD_CREG_BASE   = 32'h8007f000;
	localparam logic [31:0] IBD_LS_END_LOW  = 32'h000feffc;
	localparam logic [31:0] IBD_LS_END_HIGH = 32'hffffeffc;
	localparam logic [31:0] IBD_IF_END_LOW  = 32'h000ffffc;
	localparam logic [31:0] IBD_IF_END_HIGH = 32'hfffffffc;
	localparam logic [31:0] IBD_TOP_START   = 32'hffff0000;
	localparam int IBD_XBUS_CYCLES = 3;
	typedef enum logic [2:0] {IBD_T_NONE, IBD_T_SRAM, IBD_T_CREG, IBD_T_PERIPH, IBD_T_XBUS, IBD_T_EXT,
		IBD_T_ERR, IBD_T_MCHK} ibd_target_t;
endpackage

/* ibd_decode_properties.sv */
// Port-level checker for the internal bus decoder.
// Bound from the testbench top; sees only the decoder ports.
`timescale 1ns/1ps
module ibd_decode_properties import ibd_pkg::*; (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pprot_priv,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        req,
	input wire logic [31:0] req_addr,
	input wire logic        req_instr,
	input wire logic        done,
	input wire ibd_target_t target,
	input wire logic        out_burst,
	input wire logic        transfer_error_ack,
	input wire logic        freeze,
	input wire logic        debug_mode_en,
	input wire logic        nm_breakpoint,
	input wire logic        bus_cycle_hung,
	input wire logic        watch_timer_on,
	input wire logic        watch_timer_force_end,
	input wire logic        pit_run,
	input wire logic        periodic_irq_enable,
	input wire logic        decrementer_run
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence xbus_done_s;
		done && target == IBD_T_XBUS;
	endsequence
	sequence reg_instr_s;
		req && !done && req_instr && req_addr >= IBD_REG_BASE && req_addr <= IBD_REG_LIMIT;
	endsequence
	rdy_one_cycle_a: assert property (pready |=> !pready) else $error("pready too long");
	err_with_rdy_a: assert property (pslverr |-> pready) else $error("pslverr alone");
	user_refused_a: assert property (psel && penable && pready && !pprot_priv |-> pslverr) else $error("user ok");
	done_pulse_a: assert property (done |=> !done) else $error("done too long");
	xbus_three_a: assert property (xbus_done_s |-> $past(req, 3) && $past(req, 2) && $past(req)) else $error("xbus fast");
	xbus_single_a: assert property (xbus_done_s |-> !out_burst) else $error("xbus burst");
	instr_reg_err_a: assert property (reg_instr_s |=> done && transfer_error_ack) else $error("no tea");
	watch_forced_a: assert property (debug_mode_en && (freeze || nm_breakpoint) |=> watch_timer_on) else $error("wt");
	bp_end_a: assert property (!freeze && nm_breakpoint && bus_cycle_hung |=> watch_timer_force_end) else $error("bp");
	pit_gate_a: assert property (pit_run |-> $past(periodic_irq_enable)) else $error("pit");
	dec_free_a: assert property (!freeze |=> decrementer_run) else $error("dec");
endmodule

/* ibd_master.sv */
// Internal bus master model: one request at a time, held until done.
// Assumes done pulses once per taken request.
`timescale 1ns/1ps
module ibd_master (
	input  wire logic        pclk,
	input  wire logic        done,
	output logic             req,
	output logic [31:0]      req_addr,
	output logic             req_instr,
	output logic             req_from_if,
	output logic             req_burst
);
	initial begin
		req = 1'h0;
		req_addr = 32'h0;
		{req_instr, req_from_if, req_burst} = 3'h0;
	end
	task automatic access(input logic [31:0] a, input logic ins, fif, bst, output int lat);
		lat = 0;
		@(posedge pclk);
		req <= 1'h1;
		req_addr <= a;
		{req_instr, req_from_if, req_burst} <= {ins, fif, bst};
		do begin
			@(posedge pclk);
			lat++;
		end while (done !== 1'h1 && lat < 50);
		req <= 1'h0;
		req_addr <= ~a;
	endtask
endmodule

/* ibd_decode_tb.sv */
// Self-checking bench for ibd_decode: APB tasks, master model, freeze inputs.
// Assumes a 40 MHz clock and the decoder hand-over timing.
`timescale 1ns/1ps
bind ibd_decode ibd_decode_properties u_props (.pclk, .presetn, .psel, .penable, .pprot_priv, .pready, .pslverr,
	.req, .req_addr, .req_instr, .done, .target, .out_burst, .transfer_error_ack, .freeze, .debug_mode_en,
	.nm_breakpoint, .bus_cycle_hung, .watch_timer_on, .watch_timer_force_end, .pit_run, .periodic_irq_enable,
	.decrementer_run);
module ibd_decode_tb import ibd_pkg::*; ;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pprot_priv = 1, pready, pslverr, err;
	logic [31:0] paddr = 0, pwdata = 0, prdata, rd, req_addr, config_word = 32'h80408040;
	logic req, req_instr, req_from_if, req_burst, done, out_burst, transfer_error_ack, machine_check;
	logic freeze = 0, debug_mode_en = 0, nm_breakpoint = 0, bus_cycle_hung = 0, periodic_irq_enable = 0;
	logic watch_timer_on, watch_timer_force_end, pit_run, decrementer_run;
	ibd_target_t target;
	int n_errors = 0, num_checks = 0, cyc = 0, lat;
	ibd_decode u_ibd_decode (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pprot_priv, .prdata,
		.pready, .pslverr, .config_word, .req, .req_addr, .req_instr, .req_from_if, .req_burst, .done, .target,
		.out_burst, .transfer_error_ack, .machine_check, .freeze, .debug_mode_en, .nm_breakpoint,
		.bus_cycle_hung, .watch_timer_on, .watch_timer_force_end, .pit_run, .periodic_irq_enable,
		.decrementer_run);
	ibd_master u_ibd_master (.pclk, .done, .req, .req_addr, .req_instr, .req_from_if, .req_burst);
	always #12.5 pclk = ~pclk;
	task automatic wrap_up();
		if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			wrap_up();
		end
	end
	task automatic chk(input logic [31:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chb(input logic got, exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask
	task automatic tg(input ibd_target_t e);
		chk({29'h0, target}, {29'h0, e});
	endtask
	task automatic apb(input logic wr, input logic [31:0] a, d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, wr, a, d};
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1 && cyc < 20000);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'h0;
	endtask
	task automatic t_regs();
		apb(0, IBD_PLACEMENT_ADDR, 0);
		chk(rd, 32'h8040c040);
		apb(1, IBD_PLACEMENT_ADDR, 32'hffffffff);
		apb(0, IBD_PLACEMENT_ADDR, 0);
		chk(rd, 32'h80c0c0c0);
		pprot_priv <= 1'h0;
		apb(1, IBD_PLACEMENT_ADDR, 0);
		chb(err, 1'h1);
		pprot_priv <= 1'h1;
		apb(0, IBD_PLACEMENT_ADDR, 0);
		chk(rd, 32'h80c0c0c0);
		apb(0, 32'h8007fc04, 0);
		chk({rd[31:1], err}, 32'h1);
	endtask
	task automatic t_decode();
		logic [31:0] base [4] = '{32'h0, 32'h000fe000, 32'hffff0000, 32'hffffe000};
		for (int i = 0; i < 4; i++) begin
			apb(1, IBD_PLACEMENT_ADDR, 32'h80004000 | (i << 22));
			u_ibd_master.access(base[i], 0, 0, 0, lat);
			tg(IBD_T_SRAM);
		end
		apb(1, IBD_PLACEMENT_ADDR, 32'h80004000);
		u_ibd_master.access(32'h1000, 0, 0, 0, lat);
		chb(machine_check, 1'h1);
		u_ibd_master.access(32'h0, 0, 1, 1, lat);
		tg(IBD_T_XBUS);
		chb(lat == 4 && out_burst === 1'h0, 1'h1);
		u_ibd_master.access(IBD_CREG_BASE, 0, 0, 0, lat);
		tg(IBD_T_CREG);
		u_ibd_master.access(IBD_REG_BASE, 0, 0, 0, lat);
		tg(IBD_T_PERIPH);
		u_ibd_master.access(IBD_PLACEMENT_ADDR, 1, 0, 0, lat);
		chb(transfer_error_ack, 1'h1);
		u_ibd_master.access(32'h40000000, 0, 0, 0, lat);
		tg(IBD_T_EXT);
		apb(1, IBD_PLACEMENT_ADDR, 32'h00008040);
		u_ibd_master.access(32'h000ffff0, 1, 1, 0, lat);
		tg(IBD_T_EXT);
		u_ibd_master.access(32'h0, 0, 0, 0, lat);
		tg(IBD_T_EXT);
	endtask
	task automatic t_freeze();
		apb(1, IBD_CONFIG_ADDR, 32'h80000000);
		periodic_irq_enable <= 1'h1;
		freeze <= 1'h1;
		repeat (3) @(posedge pclk);
		chk({pit_run, decrementer_run, watch_timer_on}, 3'h0);
		apb(1, IBD_CTRL_ADDR, 32'h1);
		repeat (2) @(posedge pclk);
		chb(watch_timer_on, 1'h1);
		apb(1, IBD_LOCK_ADDR, 32'h1);
		apb(1, IBD_LOCK_ADDR, 32'h0);
		apb(0, IBD_LOCK_ADDR, 0);
		chk(rd, 32'h0);
		apb(1, IBD_CTRL_ADDR, 32'h0);
		debug_mode_en <= 1'h1;
		repeat (2) @(posedge pclk);
		chb(watch_timer_on, 1'h1);
		{freeze, debug_mode_en, nm_breakpoint, bus_cycle_hung} <= 4'h3;
		repeat (2) @(posedge pclk);
		chk({watch_timer_force_end, pit_run, decrementer_run}, 3'h7);
		apb(1, IBD_LOCK_ADDR, 32'h1);
		apb(1, IBD_LOCK_ADDR, 32'h0);
		apb(0, IBD_LOCK_ADDR, 0);
		chk(rd, 32'h1);
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		repeat (2) @(posedge pclk);
		t_regs();
		t_decode();
		t_freeze();
		wrap_up();
	end
endmodule
